// *** core/flash_burst_map.vh ***
// Register map, field positions and timing counts of the flash read port.
`ifndef FLASH_BURST_MAP_VH
`define FLASH_BURST_MAP_VH

// Register byte offsets on the APB port.
`define CFG_OFFSET 12'h000
`define STAT_OFFSET 12'h004

// Configuration field positions.
`define CFG_WAIT_LSB 0
`define CFG_WAIT_MSB 3
`define CFG_MODE_LSB 4
`define CFG_MODE_MSB 5
`define CFG_EDGE_BIT 6
`define CFG_RDY_EARLY_BIT 7
`define CFG_SYNC_BIT 8
`define CFG_REDUCED_BIT 9
`define CFG_WIDTH 10

// Reset value: asynchronous mode, rising active edge.
`define CFG_RESET 10'h040

// Burst mode encodings.
`define MODE_CONT 2'h0
`define MODE_WRAP8 2'h1
`define MODE_WRAP16 2'h2
`define MODE_WRAP32 2'h3

// Word offsets inside a 64-word block.
`define OFS_3D 6'h3D
`define OFS_3E 6'h3E
`define OFS_3F 6'h3F

// Boundary gap length in active edges, less one.
`define GAP_COUNT 2'h1

// Slowest clock without extra latency and the derived period in cycles.
`define SLOW_FREQ_KHZ 6000
`define PCLK_FREQ_KHZ 250000
`define SLOW_PERIOD_CYC ((`PCLK_FREQ_KHZ) / (`SLOW_FREQ_KHZ))

`endif

// *** core/flash_burst_read_interface.v ***
// Read-side bus interface of a banked burst flash with an APB config port.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_burst_map.vh"

module flash_burst_read_interface (
    // System clock and reset.
    input wire pclk,
    input wire presetn,
    // APB register port.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Flash pins driven by the host controller.
    input wire burst_clk,
    input wire chip_select_n,
    input wire output_enable_n,
    input wire write_enable_n,
    input wire address_valid_strobe_n,
    input wire hw_reset_n,
    input wire [20:0] address_lines,
    // Flash data and ready pins.
    output reg [15:0] data_lines_out,
    output reg data_lines_oe,
    output reg ready,
    // Memory array and program/erase status on the system clock.
    output reg [20:0] array_addr,
    input wire [15:0] array_rdata,
    input wire [3:0] bank_busy,
    input wire [15:0] status_word
);

    // One-hot states of the read engine.
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ASYNC = 7'h02;
    localparam [6:0] ST_LOAD = 7'h04;
    localparam [6:0] ST_WAIT = 7'h08;
    localparam [6:0] ST_BURST = 7'h10;
    localparam [6:0] ST_GAP = 7'h20;
    localparam [6:0] ST_STATUS = 7'h40;

    // Clock period threshold in system cycles for the saturating counter.
    localparam integer SLOW_FULL = `SLOW_PERIOD_CYC;
    // Only the low byte is kept; the threshold fits in eight bits.
    localparam [7:0] SLOW_CYC = SLOW_FULL[7:0];

    // First and second synchroniser stages for control pins.
    reg [5:0] pin_s1;
    reg [5:0] pin_s2;
    // First and second synchroniser stages for the address pins.
    reg [20:0] addr_s1;
    reg [20:0] addr_s2;
    // Previous clock and strobe levels for edge detection.
    reg clk_prev;
    reg avd_prev;
    // Configuration register.
    reg [`CFG_WIDTH-1:0] cfg;
    // Engine state.
    reg [6:0] state;
    // Initial wait counter.
    reg [4:0] wait_cnt;
    // Gap counter in active edges.
    reg [1:0] gap_cnt;
    // The first boundary gap of this burst is dropped.
    reg skip_gap;
    // Address of the word now on the data pins.
    reg [20:0] word_addr;
    // Burst clock period measurement.
    reg [7:0] period_cnt;
    reg slow;

    // Synchronised pin levels.
    wire clk_s = pin_s2[5];
    wire cs_n_s = pin_s2[4];
    wire oe_n_s = pin_s2[3];
    wire we_n_s = pin_s2[2];
    wire avd_n_s = pin_s2[1];
    wire rst_n_s = pin_s2[0];

    // Configuration fields.
    wire [3:0] cfg_wait = cfg[`CFG_WAIT_MSB:`CFG_WAIT_LSB];
    wire [1:0] cfg_mode = cfg[`CFG_MODE_MSB:`CFG_MODE_LSB];
    wire cfg_edge = cfg[`CFG_EDGE_BIT];
    wire cfg_rdy_early = cfg[`CFG_RDY_EARLY_BIT];
    wire cfg_sync = cfg[`CFG_SYNC_BIT];
    wire cfg_reduced = cfg[`CFG_REDUCED_BIT];

    // Active clock edge selected by the configuration.
    wire clk_rise = clk_s & ~clk_prev;
    wire clk_fall = ~clk_s & clk_prev;
    wire act = cfg_edge ? clk_rise : clk_fall;
    // Strobe rising edge ends the address phase.
    wire avd_rise = avd_n_s & ~avd_prev;

    // Conditions checked when leaving the word now presented.
    wire cont = (cfg_mode == `MODE_CONT);
    wire at_boundary = cont & (word_addr[5:0] == `OFS_3F)
        & cfg_reduced & ~skip_gap;
    wire bank_cross = cont & (word_addr[20:19] != array_addr[20:19]);
    wire bank_is_busy = bank_busy[array_addr[20:19]];

    // Extra initial cycles for starts near the end of a 64-word block.
    function [1:0] start_extra;
        input [5:0] ofs;
        input reduced;
        begin
            if (!reduced) begin
                start_extra = 2'h0;
            end else if (ofs == `OFS_3D) begin
                start_extra = 2'h1;
            end else if (ofs == `OFS_3E) begin
                start_extra = 2'h2;
            end else if (ofs == `OFS_3F) begin
                start_extra = 2'h3;
            end else begin
                start_extra = 2'h0;
            end
        end
    endfunction

    // Next burst address: linear rollover or wrap in an aligned group.
    function [20:0] next_address;
        input [20:0] a;
        input [1:0] mode;
        begin
            case (mode)
                `MODE_WRAP8: begin
                    next_address = {a[20:3], a[2:0] + 3'h1};
                end
                `MODE_WRAP16: begin
                    next_address = {a[20:4], a[3:0] + 4'h1};
                end
                `MODE_WRAP32: begin
                    next_address = {a[20:5], a[4:0] + 5'h01};
                end
                default: begin
                    next_address = a + 21'h000001;
                end
            endcase
        end
    endfunction

    // Two flip-flop synchronisers for every pin from the host.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // The clock stage starts at its idle low level: no false edge.
            pin_s1 <= 6'h1E;
            pin_s2 <= 6'h1E;
            addr_s1 <= 21'h000000;
            addr_s2 <= 21'h000000;
            clk_prev <= 1'b0;
            avd_prev <= 1'b1;
        end else begin
            pin_s1 <= {burst_clk, chip_select_n, output_enable_n,
                       write_enable_n, address_valid_strobe_n, hw_reset_n};
            pin_s2 <= pin_s1;
            addr_s1 <= address_lines;
            addr_s2 <= addr_s1;
            clk_prev <= clk_s;
            avd_prev <= avd_n_s;
        end
    end

    // Measures the burst clock period between rising edges.
    // A stopped clock between bursts would otherwise read as slow.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt <= 8'h00;
            slow <= 1'b0;
        end else if (!avd_n_s) begin
            // A new address restarts the measurement for this burst.
            period_cnt <= 8'h00;
            slow <= 1'b0;
        end else if (clk_rise) begin
            period_cnt <= 8'h00;
            slow <= (period_cnt >= SLOW_CYC);
        end else if (period_cnt != 8'hFF) begin
            period_cnt <= period_cnt + 8'h01;
            if (period_cnt >= SLOW_CYC) begin
                slow <= 1'b1;
            end
        end
    end

    // APB slave: no wait states, config write, status read.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `CFG_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                // Setup phase: decode and prepare the answer.
                pslverr <= (paddr != `CFG_OFFSET) & (paddr != `STAT_OFFSET);
                if (paddr == `CFG_OFFSET) begin
                    prdata <= {22'h000000, cfg};
                end else if (paddr == `STAT_OFFSET) begin
                    prdata <= {3'h0, slow, state, word_addr};
                end else begin
                    prdata <= 32'h00000000;
                end
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
            if (!rst_n_s) begin
                // The hardware reset pin restores the reset configuration.
                cfg <= `CFG_RESET;
            end else if (psel & penable & pready & pwrite
                         & (paddr == `CFG_OFFSET)) begin
                cfg <= pwdata[`CFG_WIDTH-1:0];
            end
        end
    end

    // Read engine on the sampled burst clock.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            wait_cnt <= 5'h00;
            gap_cnt <= 2'h0;
            skip_gap <= 1'b0;
            word_addr <= 21'h000000;
            array_addr <= 21'h000000;
            data_lines_out <= 16'h0000;
            data_lines_oe <= 1'b0;
            ready <= 1'b0;
        end else if (!rst_n_s || cs_n_s) begin
            // Deselect or reset pin ends any burst and floats the pins.
            state <= ST_IDLE;
            data_lines_oe <= 1'b0;
            ready <= 1'b0;
        end else begin
            // Drive only while the host reads and a word can exist.
            data_lines_oe <= ~oe_n_s & ~state[0] & ~state[2];
            if (!avd_n_s && we_n_s) begin
                // Low strobe: follow the address, restart any burst.
                array_addr <= addr_s2;
                word_addr <= addr_s2;
                ready <= cfg_sync ? 1'b0 : 1'b1;
                state <= cfg_sync ? ST_LOAD : ST_ASYNC;
            end else begin
                case (state)
                    ST_ASYNC: begin
                        // Address held from the strobe rise; word follows.
                        data_lines_out <= array_rdata;
                        ready <= 1'b1;
                    end
                    ST_LOAD: begin
                        if (avd_rise) begin
                            wait_cnt <= {1'b0, cfg_wait}
                                + {3'h0, start_extra(word_addr[5:0],
                                                     cfg_reduced)}
                                + {4'h0, slow};
                            skip_gap <= cfg_reduced
                                & (word_addr[5:0] >= `OFS_3E);
                            state <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (act) begin
                            if (wait_cnt == 5'h00) begin
                                // First word of the burst.
                                data_lines_out <= array_rdata;
                                ready <= 1'b1;
                                array_addr <= next_address(array_addr,
                                                           cfg_mode);
                                state <= ST_BURST;
                            end else begin
                                wait_cnt <= wait_cnt - 5'h01;
                                ready <= cfg_rdy_early
                                    & (wait_cnt == 5'h01);
                            end
                        end
                    end
                    ST_BURST: begin
                        if (act) begin
                            if (word_addr[5:0] == `OFS_3F) begin
                                skip_gap <= 1'b0;
                            end
                            if (bank_cross && bank_is_busy) begin
                                // Busy bank: status only, clock ignored.
                                data_lines_out <= status_word;
                                ready <= 1'b1;
                                state <= ST_STATUS;
                            end else if (at_boundary || bank_cross) begin
                                gap_cnt <= `GAP_COUNT;
                                ready <= 1'b0;
                                state <= ST_GAP;
                            end else if (slow) begin
                                gap_cnt <= 2'h0;
                                ready <= 1'b0;
                                state <= ST_GAP;
                            end else begin
                                // Advance the counter and present a word.
                                data_lines_out <= array_rdata;
                                ready <= 1'b1;
                                word_addr <= array_addr;
                                array_addr <= next_address(array_addr,
                                                           cfg_mode);
                            end
                        end
                    end
                    ST_GAP: begin
                        if (act) begin
                            if (gap_cnt == 2'h0) begin
                                // Gap over: present the pending word.
                                data_lines_out <= array_rdata;
                                ready <= 1'b1;
                                word_addr <= array_addr;
                                array_addr <= next_address(array_addr,
                                                           cfg_mode);
                                state <= ST_BURST;
                            end else begin
                                gap_cnt <= gap_cnt - 2'h1;
                            end
                        end
                    end
                    ST_STATUS: begin
                        // Holds status until a new strobe restarts.
                        data_lines_out <= status_word;
                        ready <= 1'b1;
                    end
                    default: begin
                        // Idle waits for a strobe with select low.
                        ready <= 1'b0;
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// *** test/flash_burst_chk.sv ***
// Checker for the flash read port, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "flash_burst_map.vh"
module flash_burst_chk (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Flash pins.
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic hw_reset_n,
    input wire logic data_lines_oe,
    input wire logic ready
);
    // All checks use the system clock and pause while in reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup cycle of an access, and whether its address is mapped.
    wire logic setup = psel && !penable;
    wire logic mapped = paddr == `CFG_OFFSET || paddr == `STAT_OFFSET;
    desel_float_a: assert property (
        chip_select_n [*4] |-> !data_lines_oe)
        else $error("data pins driven while deselected");
    desel_ready_a: assert property (chip_select_n [*4] |-> !ready)
        else $error("ready high while deselected");
    pin_reset_a: assert property (
        !hw_reset_n [*4] |-> !data_lines_oe && !ready)
        else $error("outputs active during pin reset");
    oe_gate_a: assert property (output_enable_n [*4] |-> !data_lines_oe)
        else $error("data pins driven with output enable off");
    apb_answer_a: assert property (setup |=> pready)
        else $error("no answer in the cycle after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (
        setup && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    cfg_width_a: assert property (
        setup && !pwrite && paddr == `CFG_OFFSET |=> prdata[31:10] == 22'h0)
        else $error("unused configuration bits read nonzero");
endmodule
bind flash_burst_read_interface flash_burst_chk chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .chip_select_n, .output_enable_n, .hw_reset_n, .data_lines_oe,
    .ready
);
`default_nettype wire

// *** test/host_model.sv ***
// Host controller model that drives the flash pins and records bursts.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // System clock.
    input wire logic pclk,
    // Pins toward the flash port.
    output logic burst_clk,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic address_valid_strobe_n,
    output logic hw_reset_n,
    output logic [20:0] address_lines,
    // Pins back from the flash port.
    input wire logic [15:0] data_lines_out,
    input wire logic ready
);
    logic [16:0] seen [$]; // Ready and word taken before each falling clock edge.
    // Idle pins: deselected, clock still, reads only.
    initial begin
        burst_clk = 1'b0;
        chip_select_n = 1'b1;
        output_enable_n = 1'b1;
        write_enable_n = 1'b1;
        address_valid_strobe_n = 1'b1;
        hw_reset_n = 1'b1;
        address_lines = 21'h0;
    end
    // Presents an address under a low strobe, then releases the lines.
    task start(input logic [20:0] a);
        @(posedge pclk);
        chip_select_n <= 1'b0;
        output_enable_n <= 1'b0;
        address_valid_strobe_n <= 1'b0;
        address_lines <= a;
        repeat (6) @(posedge pclk);
        address_valid_strobe_n <= 1'b1;
        address_lines <= ~a; // Released lines no longer show the address.
        repeat (6) @(posedge pclk);
    endtask
    // Runs the burst clock on system edges, taking ready and data before
    // each fall; the half periods average 62.5 ns.
    task clocks(input int n);
        realtime t;
        t = $realtime;
        repeat (n) begin
            t = t + 62.5;
            while ($realtime < t) @(posedge pclk);
            burst_clk <= 1'b1;
            t = t + 62.5;
            while ($realtime < t) @(posedge pclk);
            seen.push_back({ready, data_lines_out});
            burst_clk <= 1'b0;
        end
    endtask
    // Ends the current burst by deselecting.
    task deselect;
        @(posedge pclk);
        chip_select_n <= 1'b1;
        output_enable_n <= 1'b1;
    endtask
    // Pulses the hardware reset pin.
    task pin_reset;
        @(posedge pclk);
        hw_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        hw_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the flash read port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_burst_map.vh"
module tb_top;
    // APB side.
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    // Flash pins and the memory side.
    logic burst_clk, chip_select_n, output_enable_n, write_enable_n;
    logic address_valid_strobe_n, hw_reset_n, data_lines_oe, ready;
    logic [20:0] address_lines, array_addr;
    logic [15:0] data_lines_out, array_rdata, status_word;
    logic [3:0] bank_busy;
    int fails = 0, checked = 0, cycles = 0;
    // The array holds a pattern derived from each word address.
    function automatic logic [15:0] word(input logic [20:0] a);
        return a[15:0] ^ 16'hA5C3;
    endfunction
    assign array_rdata = word(array_addr);
    assign status_word = 16'h5A80;
    flash_burst_read_interface dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .burst_clk,
        .chip_select_n, .output_enable_n, .write_enable_n,
        .address_valid_strobe_n, .hw_reset_n, .address_lines,
        .data_lines_out, .data_lines_oe, .ready, .array_addr,
        .array_rdata, .bank_busy, .status_word);
    host_model host (.pclk, .burst_clk, .chip_select_n, .output_enable_n,
        .write_enable_n, .address_valid_strobe_n, .hw_reset_n,
        .address_lines, .data_lines_out, .ready);
    // System clock at 250 MHz.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            final_report;
        end
    end
    // Compares a seen value with the expected one and counts both.
    task check(input string what, input logic [31:0] exp, got);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; read data and error are taken when pready is high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Next burst address: wraps inside the group, or rolls over the top.
    function automatic logic [20:0] step(input logic [20:0] a, logic [1:0] m);
        logic [20:0] msk;
        msk = (m == `MODE_CONT) ? 21'h1FFFFF : (21'h4 << m) - 21'h1;
        return (a & ~msk) | ((a + 21'h1) & msk);
    endfunction
    // Runs one burst and compares every edge before any status stream against the expected stream.
    task run(input logic [20:0] s, input logic [9:0] c, input int n);
        logic [20:0] a, b;
        int k, lat, gap;
        logic nogap, st;
        apb(1'b1, `CFG_OFFSET, {22'h0, c});
        host.seen.delete();
        host.start(s);
        host.clocks(n);
        lat = c[3:0];
        if (c[9] && s[5:0] >= `OFS_3D) begin
            lat = lat + s[5:0] - 6'h3C;
        end
        nogap = !c[9] || s[5:0] >= `OFS_3E;
        a = s;
        gap = 0;
        st = 1'b0;
        for (k = 0; k < n; k++) begin
            if (st) begin
                // Status stream is judged by the caller.
            end else if (k < lat || gap > 0) begin
                check("ready in wait", 1'b0, host.seen[k][16]);
                if (k >= lat) gap = gap - 1;
            end else begin
                check("burst word", {1'b1, word(a)}, host.seen[k]);
                b = step(a, c[5:4]);
                if (c[5:4] == `MODE_CONT && ((a[5:0] == `OFS_3F && !nogap)
                    || b[20:19] != a[20:19])) gap = 2;
                st = b[20:19] != a[20:19] && bank_busy[b[20:19]];
                a = b;
            end
        end
    endtask
    // Reset value, field widths and unmapped places.
    task t_regs;
        apb(1'b0, `CFG_OFFSET, 32'h0);
        check("cfg reset", {22'h0, `CFG_RESET}, rd);
        apb(1'b1, `CFG_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, `CFG_OFFSET, 32'h0);
        check("cfg fields", 32'h3FF, rd);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped error", 1'b1, er);
        check("unmapped data", 32'h0, rd);
        apb(1'b1, `CFG_OFFSET, {22'h0, `CFG_RESET});
        $display("test regs done");
    endtask
    // Asynchronous read keeps the word latched at the strobe rise.
    task t_async;
        host.start(21'h012345);
        check("async word", word(21'h012345), data_lines_out);
        check("async ready", 1'b1, ready);
        check("async oe", 1'b1, data_lines_oe);
        $display("test async done");
    endtask
    // Boundary gap on reduced parts, none on standard parts.
    task t_seq_gap;
        run(21'h00003C, 10'h342, 10);
        run(21'h00003C, 10'h142, 8);
        $display("test gap done");
    endtask
    // Start offsets at the end of a block add initial latency.
    task t_reduced;
        run(21'h00013D, 10'h342, 10);
        run(21'h00013E, 10'h342, 10);
        run(21'h00013F, 10'h342, 10);
        $display("test reduced done");
    endtask
    // Bank crossing, rollover at the top, and a busy bank.
    task t_bank;
        run(21'h07FFFD, 10'h142, 8);
        run(21'h1FFFFE, 10'h142, 8);
        bank_busy <= 4'h2;
        run(21'h07FFFD, 10'h142, 10);
        check("busy status", {1'b1, status_word}, host.seen[9]);
        bank_busy <= 4'h0;
        $display("test bank done");
    endtask
    // Every wrap mode from a start that passes offset 3F.
    task t_wrap;
        int m;
        for (m = 1; m < 4; m++) begin
            run(21'h000039, 10'h342 | (m << 4), 12);
        end
        $display("test wrap done");
    endtask
    // Falling active edge, then ready raised one edge before the first word.
    task t_modes;
        int k;
        logic [20:0] b;
        apb(1'b1, `CFG_OFFSET, 32'h00000102);
        host.seen.delete();
        host.start(21'h000010);
        host.clocks(6);
        for (k = 0; k < 6; k++) begin
            if (k < 3) begin
                check("fall wait", 1'b0, host.seen[k][16]);
            end else begin
                b = 21'h00000D + k[20:0];
                check("fall word", {1'b1, word(b)}, host.seen[k]);
            end
        end
        apb(1'b1, `CFG_OFFSET, 32'h000001C2);
        host.seen.delete();
        host.start(21'h000010);
        host.clocks(4);
        check("early wait", 1'b0, host.seen[0][16]);
        check("early ready", 1'b1, host.seen[1][16]);
        check("early word", {1'b1, word(21'h000010)}, host.seen[2]);
        $display("test modes done");
    endtask
    // Deselect ends a burst; the reset pin restores the configuration.
    task t_term;
        host.start(21'h000100);
        host.clocks(4);
        host.deselect;
        repeat (8) @(posedge pclk);
        check("oe deselected", 1'b0, data_lines_oe);
        check("ready deselected", 1'b0, ready);
        host.pin_reset;
        apb(1'b0, `CFG_OFFSET, 32'h0);
        check("cfg after pin reset", {22'h0, `CFG_RESET}, rd);
        $display("test term done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task final_report;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence: reset for 20 cycles, then each test in turn.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        bank_busy = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs;
        t_async;
        t_seq_gap;
        t_reduced;
        t_bank;
        t_wrap;
        t_modes;
        t_term;
        final_report;
    end
endmodule
`default_nettype wire
